// ---- ddcin_pkg.sv ----
// shared constants, register map and encodings of the ddc input conditioning block
package ddcin_pkg;

  // data path shape
  localparam int DDCIN_DATA_W    = 16;
  localparam int DDCIN_NUM_PORTS = 4;
  localparam int DDCIN_NUM_CH    = 2;
  localparam int DDCIN_ADR_W     = 8;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] DDCIN_CH_CTRL_OFF = 8'h00;  // channel c control at 8'h00 + 4*c
  localparam logic [7:0] DDCIN_GANG_OFF    = 8'h10;
  localparam logic [7:0] DDCIN_STATUS_OFF  = 8'h14;

  // channel control, gang and status field positions
  localparam int DDCIN_SRC_W       = 3;
  localparam int DDCIN_SRC_I_LSB   = 0;
  localparam int DDCIN_SRC_Q_LSB   = 4;
  localparam int DDCIN_OFFBIN_BIT  = 8;
  localparam int DDCIN_CPLX_BIT    = 9;
  localparam int DDCIN_SWAP_BIT    = 10;
  localparam int DDCIN_ZPAD_LSB    = 12;
  localparam int DDCIN_ZPAD_W      = 2;
  localparam int DDCIN_GANG_BIT    = 0;
  localparam int DDCIN_STAT_PH_LSB = 0;
  localparam int DDCIN_STAT_DG_LSB = 16;

  // reset values
  localparam logic [31:0] DDCIN_CH_CTRL_RST = 32'h0000_0000;
  localparam logic        DDCIN_GANG_RST    = 1'b0;

  // sample source codes
  typedef enum logic [2:0] {
    DDCIN_SRC_PORT0 = 3'h0,
    DDCIN_SRC_PORT1 = 3'h1,
    DDCIN_SRC_PORT2 = 3'h2,
    DDCIN_SRC_PORT3 = 3'h3,
    DDCIN_SRC_ZERO  = 3'h4,
    DDCIN_SRC_DIG   = 3'h5,
    DDCIN_SRC_DIAG  = 3'h6,
    DDCIN_SRC_NONE  = 3'h7
  } ddcin_src_t;

  // zero padding modes: converter clock is 1, 1/2 or 1/3 of the processing clock
  typedef enum logic [1:0] {
    DDCIN_ZP_OFF  = 2'h0,
    DDCIN_ZP_DIV2 = 2'h1,
    DDCIN_ZP_DIV3 = 2'h2,
    DDCIN_ZP_RSVD = 2'h3
  } ddcin_zpad_t;

  // last slot index of a converter period per padding mode
  localparam logic [1:0] DDCIN_ZP_LAST_OFF  = 2'h0;
  localparam logic [1:0] DDCIN_ZP_LAST_DIV2 = 2'h1;
  localparam logic [1:0] DDCIN_ZP_LAST_DIV3 = 2'h2;

  // diagnostic generator: 16-bit maximal lfsr, seed is arbitrary
  localparam logic [15:0] DDCIN_DIAG_SEED = 16'hace1;
  localparam logic [15:0] DDCIN_DIAG_TAPS = 16'hb400;

endpackage : ddcin_pkg

// ---- ddcin_diag.sv ----
// diagnostic sample generator: free running pseudo random word source
`timescale 1ns/100ps
`default_nettype none

module ddcin_diag
  import ddcin_pkg::*;
#(
  parameter int W = DDCIN_DATA_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  output logic     [W-1:0]  diag_o
);

  logic [15:0] lfsr;

  // galois lfsr, one new word per processing clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr <= DDCIN_DIAG_SEED;
    end else begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ DDCIN_DIAG_TAPS) : (lfsr >> 1);
    end
  end

  // narrower paths take the top bits, wider ones repeat the word
  assign diag_o = W'({((W + 15) / 16){lfsr}} >> ((((W + 15) / 16) * 16) - W));

endmodule : ddcin_diag

`default_nettype wire

// ---- ddc_input_conditioning.sv ----
// ddc input front end: source select, format conversion, real/complex, iq swap, zero pad
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE_01: samples pass on as two's complement unless conversion is chosen.
// RULE_02: optional offset binary conversion flips the sample msb; the code flips it on port samples only, not on digital or diagnostic data.
// RULE_03: source drives its msb onto the port msb, narrow samples left aligned.
// RULE_04: source may instead copy its sign into all higher port bits.
// RULE_05: source ties unused low port bits to zero.
// RULE_06: each channel is set for real only or complex i/q input.
// RULE_07: full rate complex takes i and q from two ports in one cycle.
// RULE_08: channels may be ganged to share a higher sample throughput.
// RULE_09: at half or third converter rate the stage pads with zero samples.
// RULE_10: per channel selector picks a port, zero, digital input or diagnostic source.
// RULE_11: complex spectral inversion swaps the i and q sources.
// RULE_12: real input goes to the i path, q path is forced to zero.
// RULE_13: while padding, one slot carries the sample, the rest carry zero.
// RULE_14: all conditioning happens before the mixer with mode independent latency.
module ddc_input_conditioning
  import ddcin_pkg::*;
#(
  parameter int W      = DDCIN_DATA_W,
  parameter int NPORTS = DDCIN_NUM_PORTS,
  parameter int NCH    = DDCIN_NUM_CH
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [DDCIN_ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic                         wb_ack_o,
  output logic      [31:0]             wb_dat_o,
  input  wire logic [NPORTS*W-1:0]     adc_i,
  input  wire logic [W-1:0]            dig_i,
  output logic      [NCH*W-1:0]        ch_i_o,
  output logic      [NCH*W-1:0]        ch_q_o,
  output logic      [NCH-1:0]          ch_slot_o
);

  localparam int PIDX_W = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  // ---------------------------------------------------------------- bus slave
  logic [31:0]   ch_ctrl [NCH];
  logic          gang;
  logic [1:0]    phase   [NCH];
  logic [W-1:0]  diag_val;

  wire           bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire           bus_wr    = bus_req & wb_we_i;
  wire [5:0]     word_idx  = wb_adr_i[7:2];
  wire [5:0]     ch_base   = DDCIN_CH_CTRL_OFF[7:2];
  wire           hit_ch    = (word_idx >= ch_base) && (word_idx < ch_base + 6'(NCH));
  wire [5:0]     ch_sel    = word_idx - ch_base;
  wire           hit_gang  = (wb_adr_i == DDCIN_GANG_OFF);
  wire           hit_stat  = (wb_adr_i == DDCIN_STATUS_OFF);
  wire [31:0]    byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                              {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // status word: padding phase of each channel and the live diagnostic word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      status_word[DDCIN_STAT_PH_LSB + 2*c +: 2] = phase[c];
    end
    status_word[DDCIN_STAT_DG_LSB +: 16] = diag_val[W-1 -: 16];
  end

  // unmapped addresses still acknowledge and read as zero
  wire [31:0] rd_word = hit_ch   ? ch_ctrl[ch_sel[PIDX_W-1:0] % NCH] :
                        hit_gang ? {31'h0000_0000, gang} :
                        hit_stat ? status_word : 32'h0000_0000;

  // single wait state: ack rises one edge after the request, drops the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
    end
  end

  // gang control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gang <= DDCIN_GANG_RST;
    end else if (bus_wr && hit_gang && wb_sel_i[0]) begin
      gang <= wb_dat_i[DDCIN_GANG_BIT];
    end
  end

  // ---------------------------------------------------------------- sources
  logic [W-1:0] port_s1 [NPORTS];
  logic [W-1:0] port_s2 [NPORTS];
  logic [W-1:0] dig_d1;
  logic [W-1:0] dig_d2;

  // converter pins cross in through two flops; bit alignment is the source's job
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        port_s1[p] <= '0;
        port_s2[p] <= '0;
      end else begin
        port_s1[p] <= adc_i[p*W +: W];  // [RULE_03] [RULE_04] [RULE_05]
        port_s2[p] <= port_s1[p];
      end
    end
  end

  // the digital input needs no sync but is delayed to match the port latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dig_d1 <= '0;
      dig_d2 <= '0;
    end else begin
      dig_d1 <= dig_i;
      dig_d2 <= dig_d1;  // [RULE_14]
    end
  end

  ddcin_diag #(
    .W      (W)
  ) u_diag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .diag_o (diag_val)
  );

  // ---------------------------------------------------------------- channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire        wr_me   = bus_wr && hit_ch && (ch_sel == 6'(c));
    wire        ganged  = gang && (c != 0);
    // a ganged channel follows channel 0 but reads the next ports along
    wire [31:0] eff     = ganged ? ch_ctrl[0] : ch_ctrl[c];  // [RULE_08]
    wire [2:0]  cfg_i   = eff[DDCIN_SRC_I_LSB +: DDCIN_SRC_W];
    wire [2:0]  cfg_q   = eff[DDCIN_SRC_Q_LSB +: DDCIN_SRC_W];
    wire        is_pi   = cfg_i < 3'(NPORTS);
    wire        is_pq   = cfg_q < 3'(NPORTS);
    wire [2:0]  sel_i   = (ganged && is_pi) ? 3'((int'(cfg_i) + c) % NPORTS) : cfg_i;
    wire [2:0]  sel_q   = (ganged && is_pq) ? 3'((int'(cfg_q) + c) % NPORTS) : cfg_q;
    wire        offbin  = eff[DDCIN_OFFBIN_BIT];
    wire        cplx    = eff[DDCIN_CPLX_BIT];
    wire        swap    = eff[DDCIN_SWAP_BIT];
    wire [1:0]  zp      = eff[DDCIN_ZPAD_LSB +: DDCIN_ZPAD_W];

    // source selectors; unused codes read as constant zero
    wire [W-1:0] raw_i = is_pi ? port_s2[sel_i[PIDX_W-1:0]] :
                         (sel_i == DDCIN_SRC_DIG)  ? dig_d2 :
                         (sel_i == DDCIN_SRC_DIAG) ? diag_val : '0;  // [RULE_10]
    wire [W-1:0] raw_q = is_pq ? port_s2[sel_q[PIDX_W-1:0]] :
                         (sel_q == DDCIN_SRC_DIG)  ? dig_d2 :
                         (sel_q == DDCIN_SRC_DIAG) ? diag_val : '0;  // [RULE_10] [RULE_07]

    // msb flip only on port data, so the zero source stays a true zero
    wire [W-1:0] fmt_i = (offbin && is_pi) ? {~raw_i[W-1], raw_i[W-2:0]} : raw_i;  // [RULE_01] [RULE_02]
    wire [W-1:0] fmt_q = (offbin && is_pq) ? {~raw_q[W-1], raw_q[W-2:0]} : raw_q;  // [RULE_01] [RULE_02]

    // swap i and q for spectral inversion; real input keeps q at zero
    wire [W-1:0] map_i = (cplx && swap) ? fmt_q : fmt_i;                 // [RULE_11] [RULE_06]
    wire [W-1:0] map_q = !cplx ? '0 : (swap ? fmt_i : fmt_q);           // [RULE_12] [RULE_06]

    // last slot of one converter period; reserved code behaves as no padding
    wire [1:0]  last   = (zp == DDCIN_ZP_DIV2) ? DDCIN_ZP_LAST_DIV2 :
                         (zp == DDCIN_ZP_DIV3) ? DDCIN_ZP_LAST_DIV3 : DDCIN_ZP_LAST_OFF;
    wire        slot   = (phase[c] == 2'h0);
    wire [1:0]  next_phase = (phase[c] >= last) ? 2'h0 : phase[c] + 2'h1;

    // control write; any write also realigns the padding phase to slot 0
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ch_ctrl[c] <= DDCIN_CH_CTRL_RST;
      end else if (wr_me) begin
        ch_ctrl[c] <= (ch_ctrl[c] & ~byte_mask) | (wb_dat_i & byte_mask);
      end
    end

    // padding phase counter, free running within the converter period
    always_ff @(posedge clk_i) begin
      if (rst_i || wr_me) begin
        phase[c] <= 2'h0;
      end else begin
        phase[c] <= next_phase;  // [RULE_09]
      end
    end

    // output register: one flop after selection in every mode
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ch_i_o[c*W +: W] <= '0;
        ch_q_o[c*W +: W] <= '0;
        ch_slot_o[c]     <= 1'b0;
      end else begin
        ch_i_o[c*W +: W] <= slot ? map_i : '0;  // [RULE_13] [RULE_09] [RULE_14]
        ch_q_o[c*W +: W] <= slot ? map_q : '0;  // [RULE_13] [RULE_14]
        ch_slot_o[c]     <= slot;
      end
    end
  end

endmodule : ddc_input_conditioning

`default_nettype wire

// ---- ddcin_adc_model.sv ----
// converter and digital test source model driving the sample pins
`timescale 1ns/100ps
`default_nettype none
module ddcin_adc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hold_i,
  output logic      [63:0] adc_o,
  output logic      [15:0] dig_o
);
  logic [11:0] cnt;
  // free pattern unless held, so the latency check sees moving data;
  // reset gives the count a known start, otherwise every pin fed by the count stays unknown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 12'h000;
    end else if (!hold_i) begin
      cnt <= cnt + 12'h3a7;
    end
  end
  // ports 0/1: 12-bit source left aligned, low bits at zero
  assign adc_o[15:0]  = {cnt, 4'h0};
  assign adc_o[31:16] = {cnt ^ 12'h111, 4'h0};
  // ports 2/3: sign copied into the bits above the source
  assign adc_o[47:32] = {{4{~cnt[11]}}, ~cnt};
  assign adc_o[63:48] = {{4{cnt[10]}}, cnt[10:0], 1'b1};
  assign dig_o        = {~cnt, cnt[3:0]};
endmodule : ddcin_adc_model
`default_nettype wire

// ---- ddcin_chk.sv ----
// bus and sample stream assertions for the input conditioning block
`timescale 1ns/100ps
`default_nettype none
module ddcin_chk
  import ddcin_pkg::*;
#(parameter int W = 16, parameter int NPORTS = 4, parameter int NCH = 2) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic [DDCIN_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic                   wb_we_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  input wire logic [NPORTS*W-1:0]    adc_i,
  input wire logic [NCH*W-1:0]       ch_i_o,
  input wire logic [NCH*W-1:0]       ch_q_o,
  input wire logic [NCH-1:0]         ch_slot_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] sh;
  logic [2:0]  age;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr0 = req && wb_we_i && wb_adr_i == 8'h00;
  // shadow of channel 0 control; age counts quiet cycles so the pipe can settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh  <= 32'h0;
      age <= 3'h0;
    end else if (wr0) begin
      sh  <= wb_dat_i;
      age <= 3'h0;
    end else if (age != 3'h7) age <= age + 3'h1;
  end
  wire port0 = age > 3'h3 && sh[2:0] == 3'h0 && !sh[9] && sh[13:12] != 2'h1 && sh[13:12] != 2'h2;
  sequence two_gaps;
    !ch_slot_o[0] ##1 !ch_slot_o[0];
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_resp_a: assert property (req |=> wb_ack_o) else $error("request not answered");
  ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  pad_zero_a: assert property (!ch_slot_o[0] |-> ch_i_o[15:0] == 16'h0 && ch_q_o[15:0] == 16'h0)
    else $error("padded slot not zero");
  pad_gap_a: assert property (two_gaps |=> ch_slot_o[0]) else $error("too many padded slots");
  real_q_a: assert property (age > 3'h1 && !sh[9] |-> ch_q_o[15:0] == 16'h0)
    else $error("real mode q not zero");
  port_path_a: assert property (port0 |-> ch_i_o[15:0] == ($past(adc_i[15:0], 3) ^ {sh[8], 15'h0}))
    else $error("port sample path wrong");
endmodule : ddcin_chk
bind ddc_input_conditioning ddcin_chk #(.W(W), .NPORTS(NPORTS), .NCH(NCH)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .adc_i(adc_i), .ch_i_o(ch_i_o),
  .ch_q_o(ch_q_o), .ch_slot_o(ch_slot_o));
`default_nettype wire

// ---- ddc_input_conditioning_tb.sv ----
// self-checking bench for the input conditioning block
`timescale 1ns/100ps
`default_nettype none
module ddc_input_conditioning_tb;
  import ddcin_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, hold = 0;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'hf;
  logic [15:0] lfsr_ref, diag_d;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic [63:0] adc;
  logic [15:0] dig;
  logic [31:0] ci, cq;
  logic [1:0]  slot;
  logic        ack;
  int failures = 0, compares = 0;
  initial forever #4 clk_i = ~clk_i;
  ddcin_adc_model u_src (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .adc_o(adc), .dig_o(dig));
  ddc_input_conditioning DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_dat_o(dat_o),
    .adc_i(adc), .dig_i(dig), .ch_i_o(ci), .ch_q_o(cq), .ch_slot_o(slot));
  // reference diagnostic word stepped from reset; diag_d is what the output flop shows
  always @(posedge clk_i) begin
    if (rst_i) lfsr_ref <= DDCIN_DIAG_SEED;
    else lfsr_ref <= lfsr_ref[0] ? ((lfsr_ref >> 1) ^ DDCIN_DIAG_TAPS) : (lfsr_ref >> 1);
    diag_d <= lfsr_ref;
  end
  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; ack is read as sampled at the edge, data taken and request released there
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, sel, adr, dat} <= {1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      give_verdict();
    end
    q = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask : bus
  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic t_regs();
    bus(8'h00, 0, 0); chk(q, DDCIN_CH_CTRL_RST);
    bus(8'h10, 0, 0); chk(q, 32'h0);
    bus(8'h04, 1, 32'hf0f0_5a37); bus(8'h04, 0, 0); chk(q, 32'hf0f0_5a37);
    bus(8'h20, 1, 32'hffff_ffff); bus(8'h20, 0, 0); chk(q, 32'h0);
    bus(8'h04, 1, 32'h1234_5678, 4'h2); bus(8'h04, 0, 0); chk(q, 32'hf0f0_5637);
    bus(8'h04, 1, 0);
    bus(8'h14, 0, 0); chk(q[31:16], diag_d); chk(q[15:0], 16'h0);
  endtask : t_regs
  task automatic t_src();
    logic [15:0] e;
    for (int s = 0; s < 8; s++) begin
      bus(8'h00, 1, s);
      settle();
      e = s < 4 ? adc[s*16+:16] : (s == 5 ? dig : 16'h0);
      if (s != 6) chk(ci[15:0], e);
      else chk(ci[15:0], diag_d);
      chk(cq[15:0], 16'h0);
    end
    bus(8'h00, 1, 32'h100); settle(); chk(ci[15:0], adc[15:0] ^ 16'h8000);
  endtask : t_src
  task automatic t_cplx();
    bus(8'h00, 1, 32'h221); settle(); chk({cq[15:0], ci[15:0]}, adc[47:16]);
    bus(8'h00, 1, 32'h621); settle(); chk({ci[15:0], cq[15:0]}, adc[47:16]);
  endtask : t_cplx
  task automatic t_pad();
    int n;
    for (int m = 1; m < 3; m++) begin
      bus(8'h00, 1, m << 12);
      settle();
      n = 0;
      repeat (6) begin
        @(posedge clk_i);
        #1 n += slot[0];
        if (slot[0] !== 1'b1) chk(ci[15:0], 16'h0);
        else chk(ci[15:0], adc[15:0]);
      end
      chk(n, 6 / (m + 1));
    end
  endtask : t_pad
  task automatic t_gang();
    bus(8'h00, 1, 0); bus(8'h10, 1, 1); settle();
    chk(ci[31:16], adc[31:16]);
    chk(cq[31:16], 16'h0);
    chk(slot[1], 1'b1);
    bus(8'h10, 1, 0);
  endtask : t_gang
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    repeat (10) @(posedge clk_i);
    hold <= 1;
    t_src();
    t_cplx();
    t_pad();
    t_gang();
    give_verdict();
  end
endmodule : ddc_input_conditioning_tb
`default_nettype wire
